// *** design/wdt_defs.svh ***
// Register offsets, field positions, codes and counts of the watchdog block.
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

`define WDT_ADDR_W 5
`define WDT_OFF_CTRL 5'h00
`define WDT_OFF_RELOAD 5'h04
`define WDT_OFF_FEED 5'h08
`define WDT_OFF_COUNT 5'h0C
`define WDT_OFF_IRQ_STAT 5'h10
`define WDT_OFF_IRQ_MASK 5'h14
`define WDT_OFF_AUX 5'h18
`define WDT_OFF_CAUSE 5'h1C

`define WDT_FEED_FIRST 8'hA5
`define WDT_FEED_SECOND 8'h5A

`define WDT_CTRL_RESET 8'h00
`define WDT_RELOAD_RESET 8'hFF
`define WDT_COUNT_RESET 8'hFF
`define WDT_PRESC_W 12
`define WDT_COUNT_W 8
`define WDT_TAP_BASE 4'h4
`define WDT_RST_HOLD 5'h10
`define WDT_SOFTWARE_RESET_BIT_BIT 0
`define WDT_CAUSE_WDT_BIT 0
`define WDT_CAUSE_SW_BIT 1
`define WDT_IRQ_EXPIRY_BIT 0

`endif

// *** design/wdt_pkg.sv ***
// Types shared by the watchdog block.
package wdt_pkg;

  // Control register layout, bit 7 down to bit 0.
  typedef struct packed {
    logic [2:0] tap_sel;
    logic [1:0] rsvd;
    logic run;
    logic watchdog_reset_mode_enable;
    logic osc_sel;
  } wdt_ctrl_t;

  typedef enum logic [2:0] {
    WDT_FD_IDLE = 3'h1,
    WDT_FD_NEED_FIRST = 3'h2,
    WDT_FD_NEED_SECOND = 3'h4
  } wdt_feed_state_t;

endpackage

// *** design/wdt_edge_det.sv ***
// Rising edge detector for a slow, synchronous input level.
module wdt_edge_det (
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Level in, pulse out
  input wire logic level_i,
  output logic rise_o
);

  logic prev;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prev <= 1'b0;
    end else begin
      prev <= level_i;
    end
  end

  assign rise_o = level_i & ~prev;

endmodule

// *** design/wdt_prescaler.sv ***
// Binary prescaler with a selectable tap that emits one pulse per tap wrap.
module wdt_prescaler #(
  parameter int WIDTH = 12,
  parameter int SEL_W = 3,
  parameter int TAP_BASE = 4
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Control
  input wire logic tick_i,
  input wire logic clear_i,
  input wire logic [SEL_W-1:0] tap_sel_i,
  // Tap
  output logic tap_o
);

  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] low_mask;

  // The tap fires when every stage up to the chosen one is about to wrap,
  // so the period is 2^(TAP_BASE+sel+1) source ticks.
  always_comb begin
    low_mask = '0;
    for (int i = 0; i < WIDTH; i++) begin
      low_mask[i] = (i <= (TAP_BASE + int'(tap_sel_i)));
    end
  end

  assign tap_o = tick_i & ~clear_i & ((count & low_mask) == low_mask);

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count <= '0;
    end else if (clear_i) begin
      count <= '0;
    end else if (tick_i) begin
      count <= count + 1'b1;
    end
  end

endmodule

// *** design/wdt_top.sv ***
// Watchdog and interval timer with feed checking and a software reset bit.
`include "wdt_defs.svh"

// Notes on behaviour
// - Counter underflow without a feed forces a system reset.
// - Twelve-bit prescaler drives an eight-bit down counter.
// - Down counter steps on a chosen prescaler tap, not the source clock.
// - Prescaler source is the peripheral clock or the watchdog oscillator.
// - Only power-on reset returns configuration and state to defaults.
// - With reset mode off, the counter is an interval timer with interrupt.
// - Peripheral clock source plus power-down stops the watchdog.
// - A wrong or incomplete feed sequence forces a watchdog reset.
// - A control write must be followed at once by a valid feed.
// - Reset mode applies while the reset mode enable bit is one.
// - Setting the software reset bit resets the whole processor.
module wdt_top #(
  parameter int PRESC_W = `WDT_PRESC_W,
  parameter int COUNT_W = `WDT_COUNT_W
) (
  // Clock and power-on reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Avalon-MM slave
  input wire logic [`WDT_ADDR_W-1:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  // System side
  input wire logic wdt_osc_i,
  input wire logic power_down_i,
  output logic sys_reset_o,
  output logic irq_o
);

  import wdt_pkg::*;

  wdt_pkg::wdt_ctrl_t watchdog_control_reg;
  logic [COUNT_W-1:0] reload_value;
  logic [COUNT_W-1:0] count;
  logic [7:0] irq_status;
  logic [7:0] irq_mask;
  logic [7:0] reset_cause;
  logic [4:0] rst_hold;
  logic ack;
  wdt_pkg::wdt_feed_state_t feed_state;
  wdt_pkg::wdt_feed_state_t next_feed_state;

  logic wr;
  logic rd;
  logic [7:0] wbyte;
  logic feed_ok;
  logic feed_err;
  logic osc_rise;
  logic active;
  logic tick;
  logic tap;
  logic underflow;
  logic wdt_trip;
  logic sw_trip;
  logic software_reset_bit;

  // Bus slave: one wait cycle, then the request is taken.
  assign waitrequest_o = (read_i | write_i) & ~ack;
  assign wr = write_i & ack;
  assign rd = read_i & ack;
  assign wbyte = writedata_i[7:0];

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack <= 1'b0;
    end else begin
      ack <= (read_i | write_i) & ~ack;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      readdata_o <= 32'h0000_0000;
    end else if ((read_i | write_i) & ~ack & read_i) begin
      case (address_i)
        `WDT_OFF_CTRL: readdata_o <= {24'h00_0000, watchdog_control_reg};
        `WDT_OFF_RELOAD: readdata_o <= 32'(reload_value);
        `WDT_OFF_COUNT: readdata_o <= 32'(count);
        `WDT_OFF_IRQ_STAT: readdata_o <= {24'h00_0000, irq_status};
        `WDT_OFF_IRQ_MASK: readdata_o <= {24'h00_0000, irq_mask};
        `WDT_OFF_CAUSE: readdata_o <= {24'h00_0000, reset_cause};
        default: readdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // Configuration. Only resetn_i, the power-on reset, clears it; the
  // system reset this block drives does not loop back here.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      watchdog_control_reg <= `WDT_CTRL_RESET;
    end else if (wr && address_i == `WDT_OFF_CTRL) begin
      watchdog_control_reg <= wbyte;
      watchdog_control_reg.rsvd <= 2'h0;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reload_value <= `WDT_RELOAD_RESET;
      irq_mask <= 8'h00;
    end else if (wr) begin
      if (address_i == `WDT_OFF_RELOAD) begin
        reload_value <= wbyte[COUNT_W-1:0];
      end
      if (address_i == `WDT_OFF_IRQ_MASK) begin
        irq_mask <= wbyte;
      end
    end
  end

  // Feed sequence checker. Any other bus write between the two feed
  // bytes, or after a control write, breaks the sequence. Reads do not.
  always_comb begin
    next_feed_state = feed_state;
    feed_ok = 1'b0;
    feed_err = 1'b0;
    if (wr) begin
      case (feed_state)
        WDT_FD_IDLE: begin
          if (address_i == `WDT_OFF_CTRL) begin
            next_feed_state = WDT_FD_NEED_FIRST;
          end else if (address_i == `WDT_OFF_FEED) begin
            if (wbyte == `WDT_FEED_FIRST) begin
              next_feed_state = WDT_FD_NEED_SECOND;
            end else begin
              feed_err = 1'b1;
            end
          end
        end
        WDT_FD_NEED_FIRST: begin
          if (address_i == `WDT_OFF_FEED && wbyte == `WDT_FEED_FIRST) begin
            next_feed_state = WDT_FD_NEED_SECOND;
          end else begin
            feed_err = 1'b1;
            next_feed_state = WDT_FD_IDLE;
          end
        end
        WDT_FD_NEED_SECOND: begin
          if (address_i == `WDT_OFF_FEED && wbyte == `WDT_FEED_SECOND) begin
            feed_ok = 1'b1;
          end else begin
            feed_err = 1'b1;
          end
          next_feed_state = WDT_FD_IDLE;
        end
        default: begin
          next_feed_state = WDT_FD_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      feed_state <= WDT_FD_IDLE;
    end else begin
      feed_state <= next_feed_state;
    end
  end

  // Source selection and power-down gating. The oscillator keeps running
  // in power-down, so only the peripheral-clock source is stopped.
  wdt_edge_det u_osc_edge (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .level_i(wdt_osc_i),
    .rise_o(osc_rise)
  );

  assign active = (watchdog_control_reg.watchdog_reset_mode_enable |
                   watchdog_control_reg.run) &
                  ~(power_down_i & ~watchdog_control_reg.osc_sel);
  assign tick = active &
                (watchdog_control_reg.osc_sel ? osc_rise : 1'b1);

  wdt_prescaler #(
    .WIDTH(PRESC_W),
    .SEL_W(3),
    .TAP_BASE(int'(`WDT_TAP_BASE))
  ) u_presc (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .tick_i(tick),
    .clear_i(feed_ok),
    .tap_sel_i(watchdog_control_reg.tap_sel),
    .tap_o(tap)
  );

  assign underflow = tap & (count == '0);

  // Down counter steps only on the prescaler tap and reloads on expiry.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count <= `WDT_COUNT_RESET;
    end else if (feed_ok) begin
      count <= reload_value;
    end else if (underflow) begin
      count <= reload_value;
    end else if (tap) begin
      count <= count - 1'b1;
    end
  end

  // Reset sources. Feed errors only reset in watchdog mode; as an
  // interval timer a stray write should not take the processor down.
  assign wdt_trip = watchdog_control_reg.watchdog_reset_mode_enable &
                    (underflow | feed_err);
  assign software_reset_bit = wbyte[`WDT_SOFTWARE_RESET_BIT_BIT];
  assign sw_trip = wr & (address_i == `WDT_OFF_AUX) &
                   software_reset_bit;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_hold <= 5'h00;
    end else if (wdt_trip | sw_trip) begin
      rst_hold <= `WDT_RST_HOLD;
    end else if (rst_hold != 5'h00) begin
      rst_hold <= rst_hold - 5'h01;
    end
  end

  assign sys_reset_o = (rst_hold != 5'h00);

  // Sticky reset cause, write one to clear; a new cause wins the clear.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reset_cause <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (wr && address_i == `WDT_OFF_CAUSE && wbyte[i]) begin
          reset_cause[i] <= 1'b0;
        end
      end
      if (wdt_trip) begin
        reset_cause[`WDT_CAUSE_WDT_BIT] <= 1'b1;
      end
      if (sw_trip) begin
        reset_cause[`WDT_CAUSE_SW_BIT] <= 1'b1;
      end
    end
  end

  // Interval expiry interrupt, write one to clear, set wins the clear.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_status <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (wr && address_i == `WDT_OFF_IRQ_STAT && wbyte[i]) begin
          irq_status[i] <= 1'b0;
        end
      end
      if (underflow && !watchdog_control_reg.watchdog_reset_mode_enable) begin
        irq_status[`WDT_IRQ_EXPIRY_BIT] <= 1'b1;
      end
    end
  end

  assign irq_o = |(irq_status & irq_mask);

endmodule

// *** sim/wdt_top_asserts.sv ***
// Checker of bus timing, reset pulses and interrupt level of wdt_top.
module wdt_top_asserts #(
  parameter int PRESC_W = 12,
  parameter int COUNT_W = 8
) (
  // Clock, reset and bus
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [4:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [31:0] readdata_o,
  input wire logic waitrequest_o,
  // System side
  input wire logic wdt_osc_i,
  input wire logic power_down_i,
  input wire logic sys_reset_o,
  input wire logic irq_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  wire logic rd_done = read_i && !waitrequest_o;
  wire logic wr_done = write_i && !waitrequest_o;

  a_wait_one: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
    else $error("waitrequest held too long");
  a_rdata_hold: assert property (!read_i |=> $stable(readdata_o))
    else $error("read data moved without a read");
  a_upper_zero: assert property (rd_done |-> readdata_o[31:8] == 24'h0)
    else $error("read data wider than a byte");
  a_feed_zero: assert property (rd_done && address_i == 5'h08 |-> readdata_o == 32'h0)
    else $error("feed register read not zero");
  a_aux_zero: assert property (rd_done && address_i == 5'h18 |-> !readdata_o[0])
    else $error("soft reset bit read back");
  a_soft_rst: assert property (wr_done && address_i == 5'h18 && writedata_i[0] |=> sys_reset_o)
    else $error("soft reset not issued");
  a_rst_pulse: assert property ($rose(sys_reset_o) |-> sys_reset_o[*8] ##1 sys_reset_o[*8] ##1 !sys_reset_o)
    else $error("system reset pulse length wrong");
  a_irq_hold: assert property (irq_o && !write_i |=> irq_o)
    else $error("interrupt dropped without a write");

  c_irq: cover property ($rose(irq_o));
  c_rst: cover property ($rose(sys_reset_o));
  c_feed: cover property (wr_done && address_i == 5'h08);
endmodule

// *** sim/tb_top.sv ***
// Self-checking bench of the watchdog: timing, feeds, resets, interrupt.
`include "wdt_defs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 0;
  logic resetn_i = 0;
  logic [4:0] address_i = 0;
  logic read_i = 0;
  logic write_i = 0;
  logic [31:0] writedata_i = 0;
  logic wdt_osc_i = 0;
  logic power_down_i = 0;
  logic [31:0] readdata_o;
  logic waitrequest_o;
  logic sys_reset_o;
  logic irq_o;
  logic [31:0] q;
  int errors = 0;
  int n_compared = 0;
  int osc_cnt = 0;
  int n;
  int r;
  logic [4:0] def_a[5] = '{`WDT_OFF_CTRL, `WDT_OFF_RELOAD,
    `WDT_OFF_COUNT, `WDT_OFF_FEED, `WDT_OFF_AUX};
  logic [7:0] def_v[5] = '{`WDT_CTRL_RESET, `WDT_RELOAD_RESET,
    `WDT_COUNT_RESET, 8'h00, 8'h00};

  wdt_top DUT (.*);

  initial begin
    forever #5 clock_i = ~clock_i;
  end

  // Oscillator of 400 kHz: 125 clock cycles a half period.
  always @(posedge clock_i) begin
    osc_cnt <= (osc_cnt == 124) ? 0 : osc_cnt + 1;
    if (osc_cnt == 124) wdt_osc_i <= ~wdt_osc_i;
  end

  function automatic int expiry(int rl, int t);
    return (rl + 1) << (5 + t);
  endfunction

  function automatic bit near(int v, int e, int tol);
    return v >= e - tol && v <= e + tol;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string what);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d);
    @(posedge clock_i);
    address_i <= a;
    writedata_i <= d;
    read_i <= !wr;
    write_i <= wr;
    do @(posedge clock_i); while (waitrequest_o !== 1'b0);
    q = readdata_o;
    read_i <= 0;
    write_i <= 0;
  endtask

  task automatic feed();
    bus(1, `WDT_OFF_FEED, `WDT_FEED_FIRST);
    bus(1, `WDT_OFF_FEED, `WDT_FEED_SECOND);
  endtask

  task automatic wait_hi(input bit irq, input int lim);
    n = 0;
    while (n < lim && (irq ? irq_o : sys_reset_o) !== 1'b1) begin
      @(posedge clock_i);
      n++;
    end
  endtask

  // A wrong write after a control write or a first feed byte.
  task automatic bad(input logic [4:0] a, input logic [31:0] d,
                     input bit first);
    bus(1, `WDT_OFF_CTRL, 32'hE2);
    if (first) bus(1, `WDT_OFF_FEED, `WDT_FEED_FIRST);
    bus(1, a, d);
    wait_hi(0, 4);
    chk(n < 4, 1, "feed error reset");
    repeat (20) @(posedge clock_i);
    bus(1, `WDT_OFF_CTRL, 32'hE2);
    feed();
  endtask

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(4704));
    repeat (20) @(posedge clock_i);
    resetn_i <= 1;
    foreach (def_a[i]) begin
      bus(0, def_a[i], 0);
      chk(q, def_v[i], "reset value");
    end
    $display("defaults done");
    for (int t = 0; t < 8; t += 7) begin
      r = t ? 0 : $urandom_range(3);
      // Stop the timer first, so a short reload cannot expire again mid-setup.
      bus(1, `WDT_OFF_CTRL, 0);
      bus(1, `WDT_OFF_RELOAD, r);
      bus(1, `WDT_OFF_CTRL, {t[2:0], 5'h02});
      repeat (20) @(posedge clock_i);
      feed();
      wait_hi(0, 5000);
      chk(near(n, expiry(r, t), 4), 1, "reset delay");
      bus(0, `WDT_OFF_CAUSE, 0);
      chk(q[0], 1, "watchdog cause");
      bus(1, `WDT_OFF_CAUSE, 1);
      bus(0, `WDT_OFF_CTRL, 0);
      chk(q, {t[2:0], 5'h02}, "ctrl kept");
    end
    $display("underflow done");
    repeat (20) @(posedge clock_i);
    bad(`WDT_OFF_FEED, $urandom_range(8'hA4), 0);
    bad(`WDT_OFF_RELOAD, 0, 0);
    bad(`WDT_OFF_FEED, $urandom_range(8'h59), 1);
    bad(`WDT_OFF_IRQ_MASK, 0, 1);
    $display("feed errors done");
    bus(1, `WDT_OFF_RELOAD, 3);
    bus(1, `WDT_OFF_CTRL, 2);
    repeat (5) begin
      feed();
      wait_hi(0, 100);
      chk(n, 100, "fed, no reset");
    end
    power_down_i <= 1;
    wait_hi(0, 600);
    chk(n, 600, "stopped in power-down");
    power_down_i <= 0;
    wait_hi(0, 300);
    chk(n < 300, 1, "runs after wake");
    repeat (20) @(posedge clock_i);
    bus(1, `WDT_OFF_RELOAD, 0);
    bus(1, `WDT_OFF_CTRL, 3);
    feed();
    power_down_i <= 1;
    wait_hi(0, 9000);
    chk(near(n, 8000, 260), 1, "oscillator delay");
    power_down_i <= 0;
    repeat (20) @(posedge clock_i);
    $display("clock source done");
    bus(1, `WDT_OFF_CAUSE, 3);
    bus(1, `WDT_OFF_AUX, 1);
    wait_hi(0, 4);
    chk(n < 4, 1, "soft reset");
    bus(0, `WDT_OFF_CAUSE, 0);
    chk(q, 2, "soft cause");
    repeat (20) @(posedge clock_i);
    r = $urandom_range(3);
    bus(1, `WDT_OFF_IRQ_MASK, 1);
    bus(1, `WDT_OFF_IRQ_STAT, 1);
    bus(1, `WDT_OFF_RELOAD, r);
    bus(1, `WDT_OFF_CTRL, 4);
    feed();
    wait_hi(1, 500);
    chk(near(n, expiry(r, 0), 4), 1, "interval delay");
    chk(sys_reset_o, 0, "no reset in timer mode");
    bus(1, `WDT_OFF_IRQ_MASK, 0);
    bus(0, `WDT_OFF_IRQ_STAT, 0);
    chk(q, 1, "sticky status");
    chk(irq_o, 0, "masked irq");
    bus(1, `WDT_OFF_IRQ_MASK, 1);
    bus(1, `WDT_OFF_IRQ_STAT, 1);
    bus(0, `WDT_OFF_IRQ_STAT, 0);
    chk({q[0], irq_o}, 0, "cleared irq");
    $display("interval timer done");
    wrap_up();
  end

  initial begin
    #1000000;
    errors++;
    wrap_up();
  end
endmodule

bind wdt_top wdt_top_asserts #(.PRESC_W(PRESC_W), .COUNT_W(COUNT_W))
  u_chk (.*);
